// *** src/cdec_decoder.sv ***
`timescale 1ns/1ps
module cdec_decoder (
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    input  cdec_pkg::cdec_xlen_t        i_xlen,
    input  wire logic                   i_custom_en,
    input  wire logic                   i_fp_en,
    input  cdec_pkg::cdec_fetch_t       i_fetch,
    output cdec_pkg::cdec_result_t      o_res
);
    import cdec_pkg::*;

    logic [15:0]  ins;
    logic [1:0]   quad;
    logic [2:0]   f3;
    logic [4:0]   dest_field;
    logic [4:0]   first_src_field;
    logic [4:0]   second_src_field;
    logic [2:0]   compact_second_src_field;
    logic [5:0]   imm6;
    logic [1:0]   arith_group_opcode;
    logic [1:0]   arith_sub;
    logic         is32;
    logic         is128;
    cdec_ntl_t    ntl;
    logic         add_hint;
    cdec_result_t res;

    assign ins                      = i_fetch.instr;
    assign quad                     = ins[1:0];
    assign f3                       = ins[15:13];
    assign dest_field               = ins[11:7];
    assign first_src_field          = ins[11:7];
    assign second_src_field         = ins[6:2];
    assign compact_second_src_field = ins[4:2];
    assign imm6                     = {ins[12], ins[6:2]};
    assign arith_group_opcode       = ins[11:10];
    assign arith_sub                = ins[6:5];
    assign is32                     = (i_xlen == CDEC_XLEN32);
    assign is128                    = (i_xlen == CDEC_XLEN128);

    cdec_q2_hint u_q2_hint (
        .i_instr    (ins),
        .o_ntl      (ntl),
        .o_add_hint (add_hint)
    );

    function automatic cdec_op_t pick(input cdec_xlen_t x, input cdec_op_t a, input cdec_op_t b,
                                      input cdec_op_t c);
        pick = (x == CDEC_XLEN32) ? a : ((x == CDEC_XLEN64) ? b : c);
    endfunction : pick

    always_comb begin
        res             = '0;
        res.valid       = i_fetch.valid;
        res.cls         = CDEC_CLS_VALID;
        res.op          = CDEC_OP_NONE;
        res.ntl         = CDEC_NTL_NONE;
        if (quad == CDEC_QWIDE) begin
            res.cls = CDEC_CLS_WIDE;
        end else if (ins == 16'h0000) begin
            res.cls = CDEC_CLS_ILLEGAL;
        end else begin
            case (quad)
                CDEC_Q0: begin
                    case (f3)
                        3'h0: begin
                            res.op = CDEC_OP_ADDI4SPN;
                            if (ins[12:5] == 8'h00) res.cls = CDEC_CLS_RESERVED;
                        end
                        3'h1: res.op = is128 ? CDEC_OP_LQ : CDEC_OP_FLD;
                        3'h2: res.op = CDEC_OP_LW;
                        3'h3: res.op = pick(i_xlen, CDEC_OP_FLW, CDEC_OP_LD, CDEC_OP_LD);
                        3'h4: res.cls = CDEC_CLS_RESERVED;
                        3'h5: res.op = is128 ? CDEC_OP_SQ : CDEC_OP_FSD;
                        3'h6: res.op = CDEC_OP_SW;
                        default: res.op = pick(i_xlen, CDEC_OP_FSW, CDEC_OP_SD, CDEC_OP_SD);
                    endcase
                end
                CDEC_Q1: begin
                    case (f3)
                        3'h0: begin
                            if (dest_field == CDEC_REG_ZERO) begin
                                res.op = CDEC_OP_NOP;
                                if (imm6 != 6'h00) res.cls = CDEC_CLS_HINT;
                            end else begin
                                res.op = CDEC_OP_ADDI;
                                if (imm6 == 6'h00) res.cls = CDEC_CLS_HINT;
                            end
                        end
                        3'h1: begin
                            if (is32) begin
                                res.op = CDEC_OP_JAL;
                            end else begin
                                res.op = CDEC_OP_ADDIW;
                                if (dest_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_RESERVED;
                            end
                        end
                        3'h2: begin
                            res.op = CDEC_OP_LI;
                            if (dest_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_HINT;
                        end
                        3'h3: begin
                            if (dest_field == CDEC_REG_SP) begin
                                res.op = CDEC_OP_ADDI16SP;
                                if (imm6 == 6'h00) res.cls = CDEC_CLS_RESERVED;
                            end else begin
                                res.op = CDEC_OP_LUI;
                                if (imm6 == 6'h00) res.cls = CDEC_CLS_RESERVED;
                                else if (dest_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_HINT;
                            end
                        end
                        3'h4: begin
                            case (arith_group_opcode)
                                CDEC_ALU_SRLI, CDEC_ALU_SRAI: begin
                                    res.op = (arith_group_opcode == CDEC_ALU_SRLI) ? CDEC_OP_SRLI : CDEC_OP_SRAI;
                                    if (is32 && ins[12]) begin
                                        res.cls = CDEC_CLS_CUSTOM;
                                    end else if (!is128 && imm6 == 6'h00) begin
                                        res.cls         = CDEC_CLS_HINT;
                                        res.hint_custom = 1'b1;
                                    end
                                end
                                CDEC_ALU_ANDI: res.op = CDEC_OP_ANDI;
                                default: begin
                                    if (!ins[12]) begin
                                        case (arith_sub)
                                            2'h0:    res.op = CDEC_OP_SUB;
                                            2'h1:    res.op = CDEC_OP_XOR;
                                            2'h2:    res.op = CDEC_OP_OR;
                                            default: res.op = CDEC_OP_AND;
                                        endcase
                                    end else if (arith_sub == 2'h0 || arith_sub == 2'h1) begin
                                        res.op = (arith_sub == 2'h0) ? CDEC_OP_SUBW : CDEC_OP_ADDW;
                                        if (is32) res.cls = CDEC_CLS_RESERVED;
                                    end else begin
                                        res.cls = CDEC_CLS_RESERVED;
                                    end
                                end
                            endcase
                        end
                        3'h5: res.op = CDEC_OP_J;
                        3'h6: res.op = CDEC_OP_BEQZ;
                        default: res.op = CDEC_OP_BNEZ;
                    endcase
                end
                default: begin
                    case (f3)
                        3'h0: begin
                            res.op = CDEC_OP_SLLI;
                            if (is32 && ins[12]) begin
                                res.cls = CDEC_CLS_CUSTOM;
                            end else if (imm6 == 6'h00 && !is128) begin
                                res.cls         = CDEC_CLS_HINT;
                                res.hint_custom = 1'b1;
                            end else if (dest_field == CDEC_REG_ZERO) begin
                                res.cls         = CDEC_CLS_HINT;
                                res.hint_custom = 1'b1;
                            end
                        end
                        3'h1: begin
                            res.op = is128 ? CDEC_OP_LQSP : CDEC_OP_FLDSP;
                            // Quad stack load has no x0 form; FP form may target f0
                            if (is128 && dest_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_RESERVED;
                        end
                        3'h2: begin
                            res.op = CDEC_OP_LWSP;
                            if (dest_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_RESERVED;
                        end
                        3'h3: begin
                            res.op = pick(i_xlen, CDEC_OP_FLWSP, CDEC_OP_LDSP, CDEC_OP_LDSP);
                            if (!is32 && dest_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_RESERVED;
                        end
                        3'h4: begin
                            if (!ins[12]) begin
                                if (second_src_field == CDEC_REG_ZERO) begin
                                    res.op = CDEC_OP_JR;
                                    if (first_src_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_RESERVED;
                                end else begin
                                    res.op = CDEC_OP_MV;
                                    if (dest_field == CDEC_REG_ZERO) res.cls = CDEC_CLS_HINT;
                                end
                            end else if (second_src_field == CDEC_REG_ZERO) begin
                                res.op = (dest_field == CDEC_REG_ZERO) ? CDEC_OP_EBREAK : CDEC_OP_JALR;
                            end else begin
                                res.op  = CDEC_OP_ADD;
                                res.ntl = ntl;
                                if (add_hint || ntl != CDEC_NTL_NONE) res.cls = CDEC_CLS_HINT;
                            end
                        end
                        3'h5: res.op = is128 ? CDEC_OP_SQSP : CDEC_OP_FSDSP;
                        3'h6: res.op = CDEC_OP_SWSP;
                        default: res.op = pick(i_xlen, CDEC_OP_FSWSP, CDEC_OP_SDSP, CDEC_OP_SDSP);
                    endcase
                end
            endcase
        end
        // Floating-point forms need the FP unit present
        if (res.cls == CDEC_CLS_VALID && !i_fp_en &&
            (res.op == CDEC_OP_FLD || res.op == CDEC_OP_FSD || res.op == CDEC_OP_FLW ||
             res.op == CDEC_OP_FSW || res.op == CDEC_OP_FLDSP || res.op == CDEC_OP_FSDSP ||
             res.op == CDEC_OP_FLWSP || res.op == CDEC_OP_FSWSP)) begin
            res.cls = CDEC_CLS_RESERVED;
        end
        // Hints are not acted on, so they run as their plain operation
        res.exec_as_op = (res.cls == CDEC_CLS_VALID) || (res.cls == CDEC_CLS_HINT);
        // Valid ops carry no LR/SC restriction here; fetch and pipeline treat them like full-width forms
        res.illegal = (res.cls == CDEC_CLS_RESERVED) || (res.cls == CDEC_CLS_ILLEGAL) ||
                      (res.cls == CDEC_CLS_CUSTOM && !i_custom_en);
        if (!i_fetch.valid) begin
            res.illegal    = 1'b0;
            res.exec_as_op = 1'b0;
        end
    end

    cdec_out_reg u_out_reg (
        .i_clk  (i_clk),
        .i_nrst (i_nrst),
        .i_res  (res),
        .o_res  (o_res)
    );

endmodule : cdec_decoder

// *** src/cdec_pkg.sv ***
package cdec_pkg;

    typedef enum logic [1:0] {
        CDEC_XLEN32,
        CDEC_XLEN64,
        CDEC_XLEN128
    } cdec_xlen_t;

    typedef enum logic [2:0] {
        CDEC_CLS_VALID,
        CDEC_CLS_RESERVED,
        CDEC_CLS_CUSTOM,
        CDEC_CLS_HINT,
        CDEC_CLS_ILLEGAL,
        CDEC_CLS_WIDE
    } cdec_class_t;

    typedef enum logic [5:0] {
        CDEC_OP_NONE,
        CDEC_OP_ADDI4SPN, CDEC_OP_FLD, CDEC_OP_LQ, CDEC_OP_LW, CDEC_OP_FLW, CDEC_OP_LD,
        CDEC_OP_FSD, CDEC_OP_SQ, CDEC_OP_SW, CDEC_OP_FSW, CDEC_OP_SD,
        CDEC_OP_NOP, CDEC_OP_ADDI, CDEC_OP_JAL, CDEC_OP_ADDIW, CDEC_OP_LI, CDEC_OP_ADDI16SP,
        CDEC_OP_LUI, CDEC_OP_SRLI, CDEC_OP_SRAI, CDEC_OP_ANDI, CDEC_OP_SUB, CDEC_OP_XOR,
        CDEC_OP_OR, CDEC_OP_AND, CDEC_OP_SUBW, CDEC_OP_ADDW, CDEC_OP_J, CDEC_OP_BEQZ,
        CDEC_OP_BNEZ, CDEC_OP_SLLI, CDEC_OP_FLDSP, CDEC_OP_LQSP, CDEC_OP_LWSP, CDEC_OP_FLWSP,
        CDEC_OP_LDSP, CDEC_OP_JR, CDEC_OP_MV, CDEC_OP_EBREAK, CDEC_OP_JALR, CDEC_OP_ADD,
        CDEC_OP_FSDSP, CDEC_OP_SQSP, CDEC_OP_SWSP, CDEC_OP_FSWSP, CDEC_OP_SDSP
    } cdec_op_t;

    typedef enum logic [2:0] {
        CDEC_NTL_NONE,
        CDEC_NTL_P1,
        CDEC_NTL_PALL,
        CDEC_NTL_S1,
        CDEC_NTL_ALL
    } cdec_ntl_t;

    typedef struct packed {
        logic [15:0] instr;
        logic        valid;
    } cdec_fetch_t;

    typedef struct packed {
        logic        valid;
        cdec_class_t cls;
        cdec_op_t    op;
        cdec_ntl_t   ntl;
        logic        hint_custom;
        logic        illegal;
        logic        exec_as_op;
    } cdec_result_t;

    localparam logic [1:0] CDEC_Q0       = 2'h0;
    localparam logic [1:0] CDEC_Q1       = 2'h1;
    localparam logic [1:0] CDEC_Q2       = 2'h2;
    localparam logic [1:0] CDEC_QWIDE    = 2'h3;
    localparam logic [4:0] CDEC_REG_ZERO = 5'h00;
    localparam logic [4:0] CDEC_REG_SP   = 5'h02;
    localparam logic [4:0] CDEC_REG_X3   = 5'h03;
    localparam logic [4:0] CDEC_REG_X4   = 5'h04;
    localparam logic [4:0] CDEC_REG_X5   = 5'h05;
    localparam logic [1:0] CDEC_ALU_SRLI = 2'h0;
    localparam logic [1:0] CDEC_ALU_SRAI = 2'h1;
    localparam logic [1:0] CDEC_ALU_ANDI = 2'h2;
    localparam logic [1:0] CDEC_ALU_RR   = 2'h3;

endpackage : cdec_pkg

// *** src/cdec_q2_hint.sv ***
`timescale 1ns/1ps
module cdec_q2_hint (
    input  wire logic [15:0]        i_instr,
    output cdec_pkg::cdec_ntl_t     o_ntl,
    output logic                    o_add_hint
);
    import cdec_pkg::*;

    logic [4:0] dest_field;
    logic [4:0] second_src_field;

    assign dest_field       = i_instr[11:7];
    assign second_src_field = i_instr[6:2];

    always_comb begin
        o_ntl      = CDEC_NTL_NONE;
        o_add_hint = 1'b0;
        if (i_instr[12] && dest_field == CDEC_REG_ZERO && second_src_field != CDEC_REG_ZERO) begin
            case (second_src_field)
                CDEC_REG_SP: o_ntl = CDEC_NTL_P1;
                CDEC_REG_X3: o_ntl = CDEC_NTL_PALL;
                CDEC_REG_X4: o_ntl = CDEC_NTL_S1;
                CDEC_REG_X5: o_ntl = CDEC_NTL_ALL;
                default:     o_add_hint = 1'b1;
            endcase
        end
    end

endmodule : cdec_q2_hint

// *** src/cdec_out_reg.sv ***
`timescale 1ns/1ps
module cdec_out_reg (
    input  wire logic                   i_clk,
    input  wire logic                   i_nrst,
    input  cdec_pkg::cdec_result_t      i_res,
    output cdec_pkg::cdec_result_t      o_res
);
    import cdec_pkg::*;

    cdec_result_t res_q;
    cdec_result_t res_d;

    always_comb begin
        res_d = i_res;
    end

    // Reset clears only the output stage; decode itself is stateless
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    assign o_res = res_q;

endmodule : cdec_out_reg

// *** bench/cdec_decoder_assertions.sv ***
`timescale 1ns/1ps
module cdec_decoder_assertions
    import cdec_pkg::*;
(
    input wire logic              i_clk,
    input wire logic              i_nrst,
    input cdec_pkg::cdec_xlen_t   i_xlen,
    input wire logic              i_custom_en,
    input wire logic              i_fp_en,
    input cdec_pkg::cdec_fetch_t  i_fetch,
    input cdec_pkg::cdec_result_t o_res
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_nrst);
    logic [15:0] ins;
    logic        fv;
    assign ins = i_fetch.instr;
    assign fv  = i_fetch.valid;

    a_wide_quadrant: assert property (fv && ins[1:0] == CDEC_QWIDE |=> o_res.valid && o_res.cls == CDEC_CLS_WIDE)
        else $error("wide halfword not flagged");
    a_zero_illegal: assert property (fv && ins == 16'h0000 |=> o_res.cls == CDEC_CLS_ILLEGAL && o_res.illegal)
        else $error("zero halfword not illegal");
    a_idle_quiet: assert property (!fv |=> !o_res.valid && !o_res.illegal && !o_res.exec_as_op)
        else $error("idle cycle produced a result");
    a_ntl_select: assert property (fv && ins[15:5] == 11'h480 && ins[1:0] == CDEC_Q2 && ins[4:2] inside {[2:5]}
        |=> o_res.cls == CDEC_CLS_HINT && o_res.ntl == cdec_ntl_t'($past(ins[4:2]) - 3'h1))
        else $error("locality hint mapping wrong");
    a_ebreak_decode: assert property (fv && ins == 16'h9002 |=> o_res.op == CDEC_OP_EBREAK)
        else $error("breakpoint not decoded");
    a_jr_select: assert property (fv && ins[15:12] == 4'h8 && ins[11:7] != CDEC_REG_ZERO && ins[6:0] == 7'h02
        |=> o_res.op == CDEC_OP_JR && o_res.cls == CDEC_CLS_VALID)
        else $error("move with zero source not a jump");
    a_word_rv32_res: assert property (fv && i_xlen == CDEC_XLEN32 && ins[15:10] == 6'h27 && !ins[6] && ins[1:0] == CDEC_Q1
        |=> o_res.cls == CDEC_CLS_RESERVED && o_res.illegal)
        else $error("word op accepted on 32-bit base");
    a_ldsp_x0_res: assert property (fv && i_xlen != CDEC_XLEN32 && ins[15:13] == 3'h3 && ins[11:7] == CDEC_REG_ZERO
        && ins[1:0] == CDEC_Q2 |=> o_res.cls == CDEC_CLS_RESERVED && o_res.illegal)
        else $error("stack load to x0 not reserved");
    a_arith_select: assert property (fv && ins[15:10] == 6'h23 && ins[1:0] == CDEC_Q1
        |=> o_res.op == cdec_op_t'(CDEC_OP_SUB + $past(ins[6:5])))
        else $error("arith subfield mapping wrong");
    a_hint_runs: assert property (o_res.valid && o_res.cls == CDEC_CLS_HINT |-> o_res.exec_as_op && !o_res.illegal)
        else $error("hint does not execute quietly");
    a_res_trap: assert property (o_res.valid && o_res.cls == CDEC_CLS_RESERVED |-> o_res.illegal)
        else $error("reserved code point without trap");
    a_custom_apart: assert property (o_res.hint_custom |-> o_res.ntl == CDEC_NTL_NONE)
        else $error("custom hint given a standard meaning");

    c_ntl_seen: cover property (o_res.ntl == CDEC_NTL_ALL);
    c_custom_hint: cover property (o_res.hint_custom);
    c_reserved: cover property (o_res.cls == CDEC_CLS_RESERVED);
endmodule : cdec_decoder_assertions

bind cdec_decoder cdec_decoder_assertions u_cdec_decoder_assertions (
    .i_clk       (i_clk),
    .i_nrst      (i_nrst),
    .i_xlen      (i_xlen),
    .i_custom_en (i_custom_en),
    .i_fp_en     (i_fp_en),
    .i_fetch     (i_fetch),
    .o_res       (o_res)
);

// *** bench/cdec_fetch_model.sv ***
`timescale 1ns/1ps
module cdec_fetch_model (
    output cdec_pkg::cdec_fetch_t o_fetch
);
    import cdec_pkg::*;
    // Idle bus shows the inverse of the last halfword, so stale data never looks valid
    initial o_fetch = '{instr: 16'hFFFF, valid: 1'b0};
    task automatic drive(input logic [15:0] ins);
        o_fetch = '{instr: ins, valid: 1'b1};
    endtask : drive
    task automatic idle();
        o_fetch = '{instr: ~o_fetch.instr, valid: 1'b0};
    endtask : idle
endmodule : cdec_fetch_model

// *** bench/cdec_decoder_test.sv ***
`timescale 1ns/1ps
module cdec_decoder_test;
    import cdec_pkg::*;
    localparam cdec_xlen_t  X32 = CDEC_XLEN32;
    localparam cdec_xlen_t  X64 = CDEC_XLEN64;
    localparam cdec_xlen_t  X128 = CDEC_XLEN128;
    localparam cdec_class_t KV = CDEC_CLS_VALID;
    localparam cdec_class_t KR = CDEC_CLS_RESERVED;
    localparam cdec_class_t KC = CDEC_CLS_CUSTOM;
    localparam cdec_class_t KH = CDEC_CLS_HINT;
    logic         i_clk;
    logic         i_nrst;
    cdec_xlen_t   i_xlen;
    logic         i_custom_en;
    logic         i_fp_en;
    cdec_fetch_t  fetch;
    cdec_result_t o_res;
    int           err_count;
    int           checks;

    cdec_fetch_model u_fetch (.o_fetch(fetch));
    cdec_decoder u_cdec_decoder (.i_clk(i_clk), .i_nrst(i_nrst), .i_xlen(i_xlen), .i_custom_en(i_custom_en),
                                 .i_fp_en(i_fp_en), .i_fetch(fetch), .o_res(o_res));

    initial begin
        i_clk = 1'b0;
        forever #12.5 i_clk = ~i_clk;
    end

    task automatic end_of_test();
        if (err_count == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
        checks++;
        if (e !== g) begin
            $display("CHECK FAILED %s expected %0h seen %0h", nm, e, g);
            err_count++;
        end
    endtask : cmp

    // Back to back: drive on this falling edge, judge on the next one
    task automatic dec(input logic [15:0] ins, input cdec_xlen_t xl, input cdec_class_t c, input cdec_op_t o,
                       input logic ill, input cdec_ntl_t n = CDEC_NTL_NONE, input logic hc = 1'b0);
        i_xlen = xl;
        u_fetch.drive(ins);
        @(negedge i_clk);
        cmp("valid", 16'h0001, 16'(o_res.valid));
        cmp("class", 16'(c), 16'(o_res.cls));
        if (c == KV || c == KH) cmp("op", 16'(o), 16'(o_res.op));
        if (c != CDEC_CLS_WIDE) cmp("illegal", 16'(ill), 16'(o_res.illegal));
        if (c == KV || c == KH) cmp("ntl", 16'(n), 16'(o_res.ntl));
        if (c == KH) cmp("hint_custom", 16'(hc), 16'(o_res.hint_custom));
        if (c == KV || c == KH) cmp("exec_as_op", 16'h0001, 16'(o_res.exec_as_op));
    endtask : dec

    task automatic t_edges();
        dec(16'h0003, X32, CDEC_CLS_WIDE, CDEC_OP_NONE, 1'b0);
        dec(16'hFFFF, X128, CDEC_CLS_WIDE, CDEC_OP_NONE, 1'b0);
        dec(16'h0000, X32, CDEC_CLS_ILLEGAL, CDEC_OP_NONE, 1'b1);
        dec(16'h0000, X128, CDEC_CLS_ILLEGAL, CDEC_OP_NONE, 1'b1);
        u_fetch.idle();
        @(negedge i_clk);
        cmp("idle", 16'h0000, {13'h0000, o_res.valid, o_res.illegal, o_res.exec_as_op});
    endtask : t_edges

    task automatic t_map();
        dec(16'h0020, X32, KV, CDEC_OP_ADDI4SPN, 1'b0);
        dec(16'h0004, X32, KR, CDEC_OP_NONE, 1'b1);
        dec(16'h2000, X32, KV, CDEC_OP_FLD, 1'b0);
        dec(16'h2000, X128, KV, CDEC_OP_LQ, 1'b0);
        dec(16'h4000, X64, KV, CDEC_OP_LW, 1'b0);
        dec(16'h6000, X32, KV, CDEC_OP_FLW, 1'b0);
        dec(16'h6000, X64, KV, CDEC_OP_LD, 1'b0);
        dec(16'h8000, X64, KR, CDEC_OP_NONE, 1'b1);
        dec(16'hA000, X128, KV, CDEC_OP_SQ, 1'b0);
        dec(16'h2001, X32, KV, CDEC_OP_JAL, 1'b0);
        dec(16'h2001, X64, KR, CDEC_OP_NONE, 1'b1);
        dec(16'h2081, X128, KV, CDEC_OP_ADDIW, 1'b0);
        dec(16'hC001, X32, KV, CDEC_OP_BEQZ, 1'b0);
        dec(16'h6082, X32, KV, CDEC_OP_FLWSP, 1'b0);
        dec(16'h6082, X64, KV, CDEC_OP_LDSP, 1'b0);
        dec(16'h6002, X128, KR, CDEC_OP_NONE, 1'b1);
        dec(16'h2002, X128, KR, CDEC_OP_NONE, 1'b1);
        dec(16'h2002, X64, KV, CDEC_OP_FLDSP, 1'b0);
    endtask : t_map

    task automatic t_arith();
        dec(16'h8C01, X32, KV, CDEC_OP_SUB, 1'b0);
        dec(16'h8C21, X32, KV, CDEC_OP_XOR, 1'b0);
        dec(16'h8C41, X32, KV, CDEC_OP_OR, 1'b0);
        dec(16'h8C61, X32, KV, CDEC_OP_AND, 1'b0);
        dec(16'h9C01, X32, KR, CDEC_OP_NONE, 1'b1);
        dec(16'h9C01, X64, KV, CDEC_OP_SUBW, 1'b0);
        dec(16'h9C21, X128, KV, CDEC_OP_ADDW, 1'b0);
        dec(16'h9C41, X64, KR, CDEC_OP_NONE, 1'b1);
        dec(16'h9C61, X128, KR, CDEC_OP_NONE, 1'b1);
    endtask : t_arith

    task automatic t_hints();
        dec(16'h0005, X32, KH, CDEC_OP_NOP, 1'b0);
        dec(16'h0081, X32, KH, CDEC_OP_ADDI, 1'b0);
        dec(16'h4001, X32, KH, CDEC_OP_LI, 1'b0);
        dec(16'h6005, X32, KH, CDEC_OP_LUI, 1'b0);
        dec(16'h8006, X32, KH, CDEC_OP_MV, 1'b0);
        dec(16'h9006, X32, KH, CDEC_OP_ADD, 1'b0);
        dec(16'h903E, X64, KH, CDEC_OP_ADD, 1'b0);
        dec(16'h900A, X32, KH, CDEC_OP_ADD, 1'b0, CDEC_NTL_P1);
        dec(16'h900E, X32, KH, CDEC_OP_ADD, 1'b0, CDEC_NTL_PALL);
        dec(16'h9012, X64, KH, CDEC_OP_ADD, 1'b0, CDEC_NTL_S1);
        dec(16'h9016, X128, KH, CDEC_OP_ADD, 1'b0, CDEC_NTL_ALL);
        dec(16'h0006, X64, KH, CDEC_OP_SLLI, 1'b0, CDEC_NTL_NONE, 1'b1);
        dec(16'h0082, X32, KH, CDEC_OP_SLLI, 1'b0, CDEC_NTL_NONE, 1'b1);
        dec(16'h0082, X128, KV, CDEC_OP_SLLI, 1'b0);
        dec(16'h0002, X128, KH, CDEC_OP_SLLI, 1'b0, CDEC_NTL_NONE, 1'b1);
        dec(16'h8001, X32, KH, CDEC_OP_SRLI, 1'b0, CDEC_NTL_NONE, 1'b1);
        dec(16'h8401, X64, KH, CDEC_OP_SRAI, 1'b0, CDEC_NTL_NONE, 1'b1);
        dec(16'h8001, X128, KV, CDEC_OP_SRLI, 1'b0);
    endtask : t_hints

    task automatic t_jumps_custom();
        dec(16'h8082, X32, KV, CDEC_OP_JR, 1'b0);
        dec(16'h8086, X32, KV, CDEC_OP_MV, 1'b0);
        dec(16'h9002, X64, KV, CDEC_OP_EBREAK, 1'b0);
        dec(16'h9082, X64, KV, CDEC_OP_JALR, 1'b0);
        dec(16'h9001, X32, KC, CDEC_OP_NONE, 1'b1);
        i_custom_en = 1'b1;
        dec(16'h9001, X32, KC, CDEC_OP_NONE, 1'b0);
        dec(16'h1006, X32, KC, CDEC_OP_NONE, 1'b0);
        i_fp_en = 1'b0;
        dec(16'h2000, X64, KR, CDEC_OP_NONE, 1'b1);
        i_fp_en = 1'b1;
    endtask : t_jumps_custom

    task automatic t_mid_reset();
        u_fetch.drive(16'h4000);
        i_nrst = 1'b0;
        #1;
        cmp("reset out", 16'h0000, o_res);
        repeat (2) @(negedge i_clk);
        i_nrst = 1'b1;
        dec(16'h9016, X32, KH, CDEC_OP_ADD, 1'b0, CDEC_NTL_ALL);
    endtask : t_mid_reset

    initial begin
        repeat (2000) @(posedge i_clk);
        err_count++;
        end_of_test();
    end

    initial begin
        err_count = 0;
        checks = 0;
        i_nrst = 1'b0;
        i_xlen = X32;
        i_custom_en = 1'b0;
        i_fp_en = 1'b1;
        repeat (12) @(posedge i_clk);
        cmp("reset out", 16'h0000, o_res);
        @(negedge i_clk);
        i_nrst = 1'b1;
        t_edges();
        t_map();
        t_arith();
        t_hints();
        t_jumps_custom();
        t_mid_reset();
        end_of_test();
    end
endmodule : cdec_decoder_test
